/* File: rpb_pkg.sv */
// constants, types and state layouts for the rgb pwm and boost control block
package rpb_pkg;

  // ==================================================================
  // clock and timing
  localparam int CLK_HZ = 20_000_000;
  localparam int SOFT_START_MS = 10;
  localparam int SOFT_START_CYC = CLK_HZ / 1000 * SOFT_START_MS;
  localparam int SLOT_HZ_FAST = 2_500_000;
  localparam int SLOT_HZ_MID = 1_250_000;
  localparam int SLOT_HZ_SLOW = 625_000;
  localparam logic [4:0] SLOT_DIV_FAST = 5'(CLK_HZ / SLOT_HZ_FAST - 1);
  localparam logic [4:0] SLOT_DIV_MID = 5'(CLK_HZ / SLOT_HZ_MID - 1);
  localparam logic [4:0] SLOT_DIV_SLOW = 5'(CLK_HZ / SLOT_HZ_SLOW - 1);
  localparam int SW_HZ_HI = 2_000_000;
  localparam int SW_HZ_MID = 1_666_667;
  localparam int SW_HZ_LO = 1_000_000;
  localparam logic [3:0] SW_HALF_HI = 4'((CLK_HZ + SW_HZ_HI) / (2 * SW_HZ_HI) - 1);
  localparam logic [3:0] SW_HALF_MID = 4'((CLK_HZ + SW_HZ_MID) / (2 * SW_HZ_MID) - 1);
  localparam logic [3:0] SW_HALF_LO = 4'((CLK_HZ + SW_HZ_LO) / (2 * SW_HZ_LO) - 1);

  // ==================================================================
  // pwm geometry
  localparam logic [5:0] PWM_SLOTS = 6'h3F;
  localparam logic [5:0] PWM_LAST_SLOT = 6'h3E;
  localparam logic [5:0] PWM_MID_SLOT = 6'h1F;
  localparam logic [5:0] SET_PHASE_STEP = 6'h10;
  localparam int NUM_SETS = 4;
  localparam int NUM_CH = 12;

  // ==================================================================
  // register map
  localparam logic [7:0] ADDR_LEVEL_FIRST = 8'h00;
  localparam logic [7:0] ADDR_LEVEL_LAST = 8'h0B;
  localparam logic [7:0] ADDR_BOOST_LEVEL = 8'h0F;
  localparam logic [7:0] ADDR_SWITCH_RATE = 8'h10;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h60;
  localparam logic [7:0] RST_LEVEL = 8'h00;
  localparam logic [7:0] RST_BOOST_LEVEL = 8'h3F;
  localparam logic [2:0] RST_SWITCH_RATE = 3'h7;
  localparam int SCALE_MSB = 7;
  localparam int SCALE_LSB = 6;
  localparam int DUTY_MSB = 5;

  // ==================================================================
  // enumerations
  typedef enum logic [1:0] {
    SW_RATE_1M = 2'b00,
    SW_RATE_1M67 = 2'b01,
    SW_RATE_2M = 2'b10
  } rpb_sw_rate_e;

  typedef enum logic [1:0] {
    BOOST_OFF = 2'b00,
    BOOST_SOFT = 2'b01,
    BOOST_RUN = 2'b10
  } rpb_boost_e;

  // ==================================================================
  // state records
  typedef struct packed {
    logic [4:0] slot_div;
    logic [5:0] slot;
    logic slot_tick;
    logic [3:0] sw_div;
    logic sw_clk;
  } rpb_tb_s;

  typedef struct packed {
    logic [NUM_CH-1:0][7:0] level;
    logic [7:0] boost_level;
    logic [2:0] switch_rate;
    rpb_boost_e boost_state;
    logic [17:0] soft_cnt;
    logic [NUM_CH-1:0] sink_on;
    logic [7:0] rdata;
    logic sink_load;
    logic boost_on;
    logic soft_on;
  } rpb_top_s;

endpackage

/* File: rpb_timebase.sv */
// pwm slot counter and boost switching clock divider from the one oscillator
`timescale 1ns/1ps
`default_nettype none
module rpb_timebase (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // selections
  input wire logic [1:0] pwm_rate,
  input wire rpb_pkg::rpb_sw_rate_e sw_rate,
  input wire logic sw_run,
  // timing out
  output logic slot_tick,
  output logic [5:0] slot,
  output logic sw_clk
);

  rpb_pkg::rpb_tb_s st_r;
  rpb_pkg::rpb_tb_s st_nxt;
  logic [4:0] div_lim;
  logic [3:0] half_lim;

  // ==================================================================
  // divider limits
  always_comb begin
    case (pwm_rate)
      2'b00: div_lim = rpb_pkg::SLOT_DIV_SLOW;
      2'b01: div_lim = rpb_pkg::SLOT_DIV_MID;
      default: div_lim = rpb_pkg::SLOT_DIV_FAST;
    endcase
    case (sw_rate)
      rpb_pkg::SW_RATE_2M: half_lim = rpb_pkg::SW_HALF_HI;
      rpb_pkg::SW_RATE_1M67: half_lim = rpb_pkg::SW_HALF_MID;
      default: half_lim = rpb_pkg::SW_HALF_LO;
    endcase
  end

  // ==================================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.slot_tick = 1'b0;
    if (st_r.slot_div >= div_lim) begin
      st_nxt.slot_div = 5'h00;
      st_nxt.slot_tick = 1'b1;
      // free-running 63-slot period
      st_nxt.slot = (st_r.slot >= rpb_pkg::PWM_LAST_SLOT) ? 6'h00 : st_r.slot + 6'h01;
    end else begin
      st_nxt.slot_div = st_r.slot_div + 5'h01;
    end
    // switching clock stops low while the converter is halted
    if (!sw_run) begin
      st_nxt.sw_div = 4'h0;
      st_nxt.sw_clk = 1'b0;
    end else if (st_r.sw_div >= half_lim) begin
      st_nxt.sw_div = 4'h0;
      st_nxt.sw_clk = ~st_r.sw_clk;
    end else begin
      st_nxt.sw_div = st_r.sw_div + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign slot_tick = st_r.slot_tick;
  assign slot = st_r.slot;
  assign sw_clk = st_r.sw_clk;

endmodule
`default_nettype wire

/* File: rpb_top.sv */
// register file, phased rgb pwm outputs and boost sequencing
`timescale 1ns/1ps
`default_nettype none
module rpb_top #(
  parameter int SOFT_START_CYCLES = rpb_pkg::SOFT_START_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // control bits
  input wire logic device_awake,
  input wire logic [3:0] color_set_enable,
  input wire logic boost_enable,
  input wire logic light_load_sink_enable,
  input wire logic pwm_rate_select_hi,
  input wire logic pwm_rate_select_lo,
  // led sinks
  output logic [11:0] led_sink_on,
  output logic [23:0] led_current_scale,
  // boost stage
  output logic boost_run,
  output logic pulse_frequency_mode,
  output logic boost_switch_clk,
  output logic [7:0] boost_level,
  output logic light_load_sink_on
);

  rpb_pkg::rpb_top_s st_r;
  rpb_pkg::rpb_top_s st_nxt;
  logic soft_rst;
  logic blk_rst;
  logic slot_tick;
  logic [5:0] slot;
  rpb_pkg::rpb_sw_rate_e sw_rate;
  logic [2:0] sel;

  // ==================================================================
  // helpers
  function automatic rpb_pkg::rpb_sw_rate_e sw_decode(input logic [2:0] f);
    if (f[2]) begin
      sw_decode = rpb_pkg::SW_RATE_2M;
    end else if (f[1]) begin
      sw_decode = rpb_pkg::SW_RATE_1M67;
    end else begin
      sw_decode = rpb_pkg::SW_RATE_1M;
    end
  endfunction

  // one-hot register select shared by the write and read paths
  function automatic logic [2:0] reg_sel(input logic [7:0] a);
    reg_sel = 3'h0;
    if (a <= rpb_pkg::ADDR_LEVEL_LAST) begin
      reg_sel = 3'h1;
    end else if (a == rpb_pkg::ADDR_BOOST_LEVEL) begin
      reg_sel = 3'h2;
    end else if (a == rpb_pkg::ADDR_SWITCH_RATE) begin
      reg_sel = 3'h4;
    end
  endfunction

  // slot position within a set's own period, shifted per set
  function automatic logic [5:0] set_pos(input logic [5:0] s, input logic [1:0] set);
    logic [6:0] t;
    logic [6:0] off;
    off = 7'(set) * 7'(rpb_pkg::SET_PHASE_STEP);
    t = 7'(s) + 7'(rpb_pkg::PWM_SLOTS) - off;
    if (t >= 7'(rpb_pkg::PWM_SLOTS)) begin
      t = t - 7'(rpb_pkg::PWM_SLOTS);
    end
    set_pos = t[5:0];
  endfunction

  // colour 0 leads, 1 centred, 2 trails
  function automatic logic pwm_hit(input logic [5:0] p, input logic [5:0] n,
                                   input logic [1:0] color);
    logic [6:0] gs;
    gs = 7'(rpb_pkg::PWM_MID_SLOT) - 7'(n[5:1]);
    case (color)
      2'd0: pwm_hit = p < n;
      2'd1: pwm_hit = (7'(p) >= gs) && (7'(p) < gs + 7'(n));
      default: pwm_hit = 7'(p) >= 7'(rpb_pkg::PWM_SLOTS) - 7'(n);
    endcase
  endfunction

  // ==================================================================
  // soft reset by write to the reset address
  assign soft_rst = reg_wr && (reg_addr == rpb_pkg::ADDR_SOFT_RESET);
  assign blk_rst = rst || soft_rst;
  assign sw_rate = sw_decode(st_r.switch_rate);
  assign sel = reg_sel(reg_addr);

  rpb_timebase u_timebase (
    .clk(clk),
    .rst(blk_rst),
    .pwm_rate({pwm_rate_select_hi, pwm_rate_select_lo}),
    .sw_rate(sw_rate),
    .sw_run(st_r.boost_on),
    .slot_tick(slot_tick),
    .slot(slot),
    .sw_clk(boost_switch_clk)
  );

  // ==================================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    // register writes
    if (reg_wr) begin
      if (sel[0]) begin
        st_nxt.level[reg_addr[3:0]] = reg_wdata;
      end else if (sel[1]) begin
        st_nxt.boost_level = reg_wdata;
      end else if (sel[2]) begin
        st_nxt.switch_rate = reg_wdata[2:0];
      end
    end
    // register reads, unmapped addresses answer zero
    if (reg_rd) begin
      if (sel[0]) begin
        st_nxt.rdata = st_r.level[reg_addr[3:0]];
      end else if (sel[1]) begin
        st_nxt.rdata = st_r.boost_level;
      end else if (sel[2]) begin
        st_nxt.rdata = {5'h00, st_r.switch_rate};
      end else begin
        st_nxt.rdata = 8'h00;
      end
    end
    // boost sequencing
    case (st_r.boost_state)
      rpb_pkg::BOOST_OFF: begin
        st_nxt.soft_cnt = 18'h00000;
        if (boost_enable) begin
          st_nxt.boost_state = rpb_pkg::BOOST_SOFT;
        end
      end
      rpb_pkg::BOOST_SOFT: begin
        st_nxt.soft_cnt = st_r.soft_cnt + 18'h00001;
        if (!boost_enable) begin
          st_nxt.boost_state = rpb_pkg::BOOST_OFF;
        end else if (st_r.soft_cnt >= 18'(SOFT_START_CYCLES - 1)) begin
          st_nxt.boost_state = rpb_pkg::BOOST_RUN;
        end
      end
      rpb_pkg::BOOST_RUN: begin
        if (!boost_enable) begin
          st_nxt.boost_state = rpb_pkg::BOOST_OFF;
        end
      end
      default: begin
        st_nxt.boost_state = rpb_pkg::BOOST_OFF;
      end
    endcase
    // boost pins leave from flops, decoded from the next state
    st_nxt.boost_on = st_nxt.boost_state != rpb_pkg::BOOST_OFF;
    st_nxt.soft_on = st_nxt.boost_state == rpb_pkg::BOOST_SOFT;
    st_nxt.sink_load = light_load_sink_enable;
    // led sink comparison, one per output
    for (int i = 0; i < rpb_pkg::NUM_CH; i++) begin
      st_nxt.sink_on[i] = device_awake
        && color_set_enable[i / 3]
        && pwm_hit(set_pos(slot, 2'(i / 3)), st_r.level[i][rpb_pkg::DUTY_MSB:0], 2'(i % 3));
    end
  end

  // ==================================================================
  // state register
  always_ff @(posedge clk) begin
    if (blk_rst) begin
      st_r.level <= {rpb_pkg::NUM_CH{rpb_pkg::RST_LEVEL}};
      st_r.boost_level <= rpb_pkg::RST_BOOST_LEVEL;
      st_r.switch_rate <= rpb_pkg::RST_SWITCH_RATE;
      st_r.boost_state <= rpb_pkg::BOOST_OFF;
      st_r.soft_cnt <= 18'h00000;
      st_r.sink_on <= 12'h000;
      st_r.rdata <= 8'h00;
      st_r.sink_load <= 1'b0;
      st_r.boost_on <= 1'b0;
      st_r.soft_on <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==================================================================
  // outputs
  always_comb begin
    for (int i = 0; i < rpb_pkg::NUM_CH; i++) begin
      led_current_scale[2*i +: 2] = st_r.level[i][rpb_pkg::SCALE_MSB:rpb_pkg::SCALE_LSB];
    end
  end

  assign led_sink_on = st_r.sink_on;
  assign reg_rdata = st_r.rdata;
  assign boost_run = st_r.boost_on;
  assign pulse_frequency_mode = st_r.soft_on;
  assign boost_level = st_r.boost_level;
  assign light_load_sink_on = st_r.sink_load;

endmodule
`default_nettype wire

/* File: rpb_top_asserts.sv */
// port-level checks for the rgb pwm and boost control block
`timescale 1ns/1ps
`default_nettype none
module rpb_top_asserts #(
  parameter int SOFT_START_CYCLES = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // control bits
  input wire logic device_awake,
  input wire logic [3:0] color_set_enable,
  input wire logic boost_enable,
  input wire logic light_load_sink_enable,
  input wire logic pwm_rate_select_hi,
  input wire logic pwm_rate_select_lo,
  // outputs
  input wire logic [11:0] led_sink_on,
  input wire logic [23:0] led_current_scale,
  input wire logic boost_run,
  input wire logic pulse_frequency_mode,
  input wire logic boost_switch_clk,
  input wire logic [7:0] boost_level,
  input wire logic light_load_sink_on
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic sr;
  logic [11:0] en_m;
  logic [17:0] pc_r;
  // ==================================================================
  // helpers
  assign sr = reg_wr && reg_addr == 8'h60;
  assign en_m = {{3{color_set_enable[3]}}, {3{color_set_enable[2]}},
                 {3{color_set_enable[1]}}, {3{color_set_enable[0]}}};
  always_ff @(posedge clk) begin
    pc_r <= pulse_frequency_mode ? pc_r + 18'h1 : 18'h0;
  end
  // ==================================================================
  // properties
  sequence s_start;
    !boost_run && boost_enable && !sr;
  endsequence
  property p_awake; !device_awake |=> led_sink_on == 12'h000; endproperty
  property p_set; 1 |=> (led_sink_on & ~$past(en_m)) == 12'h000; endproperty
  property p_load; !sr |=> light_load_sink_on == $past(light_load_sink_enable); endproperty
  property p_off; !boost_enable |=> !boost_run && !pulse_frequency_mode; endproperty
  property p_start; s_start |=> boost_run && pulse_frequency_mode; endproperty
  property p_soft_len; pulse_frequency_mode |-> pc_r < SOFT_START_CYCLES; endproperty
  property p_soft_end;
    pulse_frequency_mode && pc_r == SOFT_START_CYCLES - 1 && boost_enable && !sr
      |=> boost_run && !pulse_frequency_mode;
  endproperty
  property p_level; reg_wr && reg_addr == 8'h0F |=> boost_level == $past(reg_wdata); endproperty
  property p_scale;
    reg_wr && reg_addr <= 8'h0B
      |=> led_current_scale[2 * $past(reg_addr) +: 2] == ($past(reg_wdata) >> 6);
  endproperty
  property p_srst;
    sr |=> boost_level == 8'h3F && !boost_run && led_current_scale == 24'h0;
  endproperty
  a_awake: assert property (p_awake) else $error("sinks on while asleep");
  a_set: assert property (p_set) else $error("disabled set drives");
  a_load: assert property (p_load) else $error("load sink wrong");
  a_off: assert property (p_off) else $error("boost not halted");
  a_start: assert property (p_start) else $error("no soft start");
  a_soft_len: assert property (p_soft_len) else $error("soft start too long");
  a_soft_end: assert property (p_soft_end) else $error("soft start not ended");
  a_level: assert property (p_level) else $error("boost level not written");
  a_scale: assert property (p_scale) else $error("current scale wrong");
  a_srst: assert property (p_srst) else $error("soft reset missed");
endmodule
`default_nettype wire

/* File: rpb_led_model.sv */
// led sinks and boost stage: counts on-time and switch half periods
`timescale 1ns/1ps
`default_nettype none
module rpb_led_model (
  // clock and count clear
  input wire logic clk,
  input wire logic clr,
  // from the block
  input wire logic [11:0] led_sink_on,
  input wire logic boost_switch_clk,
  // measurements
  output logic [11:0][11:0] on_cnt,
  output logic [4:0] half_len
);
  logic last_r;
  logic [4:0] run_r;
  always_ff @(posedge clk) begin
    for (int i = 0; i < 12; i++) begin
      on_cnt[i] <= clr ? 12'h000 : on_cnt[i] + 12'(led_sink_on[i]);
    end
    last_r <= boost_switch_clk;
    run_r <= (boost_switch_clk != last_r) ? 5'h01 : run_r + 5'h01;
    if (boost_switch_clk != last_r) begin
      half_len <= run_r;
    end
  end
endmodule
`default_nettype wire

/* File: rpb_top_tb.sv */
// self-checking bench for the rgb pwm and boost control block
`timescale 1ns/1ps
`default_nettype none
module rpb_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic device_awake = 1'b0;
  logic [3:0] color_set_enable = 4'h0;
  logic boost_enable = 1'b0;
  logic light_load_sink_enable = 1'b0;
  logic [1:0] pwm_rate = 2'h0;
  logic clr = 1'b0;
  logic [7:0] reg_rdata;
  logic [11:0] led_sink_on;
  logic [23:0] led_current_scale;
  logic boost_run, pulse_frequency_mode, boost_switch_clk, light_load_sink_on;
  logic [7:0] boost_level;
  logic [11:0][11:0] on_cnt;
  logic [4:0] half_len;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;
  int per;
  int t0;
  int t1;
  always #25 clk = ~clk;
  rpb_top #(.SOFT_START_CYCLES(20)) rpb_top_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .device_awake(device_awake), .color_set_enable(color_set_enable),
    .boost_enable(boost_enable), .light_load_sink_enable(light_load_sink_enable),
    .pwm_rate_select_hi(pwm_rate[1]), .pwm_rate_select_lo(pwm_rate[0]),
    .led_sink_on(led_sink_on), .led_current_scale(led_current_scale),
    .boost_run(boost_run), .pulse_frequency_mode(pulse_frequency_mode),
    .boost_switch_clk(boost_switch_clk), .boost_level(boost_level),
    .light_load_sink_on(light_load_sink_on));
  rpb_led_model rpb_led_model_inst (.clk(clk), .clr(clr), .led_sink_on(led_sink_on),
    .boost_switch_clk(boost_switch_clk), .on_cnt(on_cnt), .half_len(half_len));
  // ==================================================================
  // tasks
  task automatic stop_test;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(16'(reg_rdata), 16'(exp));
  endtask
  // settle 40 cycles first, then count over exactly n cycles
  task automatic window(input int n);
    repeat (40) @(negedge clk);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    repeat (n) @(negedge clk);
  endtask
  // cycle count at the next rise of one sink
  task automatic rise_at(input int b, output int t);
    while (led_sink_on[b] !== 1'b0) @(negedge clk);
    while (led_sink_on[b] !== 1'b1) @(negedge clk);
    t = cyc;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      stop_test;
    end
  end
  // ==================================================================
  // sequence
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    rd(8'h0F, 8'h3F);
    rd(8'h10, 8'h07);
    wr(8'h0B, 8'hFF);
    rd(8'h0B, 8'hFF);
    rd(8'h20, 8'h00);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h07);
    wr(8'h0F, 8'h7F);
    rd(8'h0F, 8'h7F);
    chk(16'(boost_level), 16'h007F);
    wr(8'h60, 8'h5A);
    rd(8'h0B, 8'h00);
    rd(8'h0F, 8'h3F);
    light_load_sink_enable = 1'b1;
    @(negedge clk);
    chk(16'(light_load_sink_on), 16'h0001);
    light_load_sink_enable = 1'b0;
    device_awake = 1'b1;
    color_set_enable = 4'h1;
    wr(8'h00, 8'hD0);
    wr(8'h01, 8'h7F);
    wr(8'h02, 8'h81);
    wr(8'h03, 8'h20);
    chk(16'(led_current_scale[7:0]), 16'h0027);
    for (int k = 0; k < 4; k++) begin
      pwm_rate = 2'(k);
      per = (k == 0) ? 32 : (k == 1) ? 16 : 8;
      window(63 * per);
      chk(16'(on_cnt[0]), 16'(16 * per));
      chk(16'(on_cnt[1]), 16'(63 * per));
      chk(16'(on_cnt[2]), 16'(per));
      chk(16'(on_cnt[3]), 16'h0000);
    end
    color_set_enable = 4'h2;
    window(504);
    chk(16'(on_cnt[0]), 16'h0000);
    chk(16'(on_cnt[3]), 16'h0100);
    device_awake = 1'b0;
    window(504);
    chk(16'(on_cnt[3]), 16'h0000);
    device_awake = 1'b1;
    color_set_enable = 4'h3;
    wr(8'h00, 8'h01);
    wr(8'h01, 8'h01);
    wr(8'h03, 8'h01);
    // one-slot pulses at slots 0, 16, 31 and 62, eight clocks a slot
    rise_at(0, t0);
    rise_at(3, t1);
    chk(16'(t1 - t0), 16'h0080);
    rise_at(1, t1);
    chk(16'(t1 - t0), 16'h00F8);
    rise_at(2, t1);
    chk(16'(t1 - t0), 16'h01F0);
    rise_at(0, t1);
    chk(16'(t1 - t0), 16'h01F8);
    boost_enable = 1'b1;
    @(negedge clk);
    chk(16'({boost_run, pulse_frequency_mode}), 16'h0003);
    repeat (25) @(negedge clk);
    chk(16'({boost_run, pulse_frequency_mode}), 16'h0002);
    for (int k = 0; k < 3; k++) begin
      wr(8'h10, 8'(4 >> k));
      repeat (40) @(negedge clk);
      chk(16'(half_len), (k == 0) ? 16'h0005 : (k == 1) ? 16'h0006 : 16'h000A);
    end
    boost_enable = 1'b0;
    @(negedge clk);
    chk(16'(boost_run), 16'h0000);
    boost_enable = 1'b1;
    @(negedge clk);
    chk(16'({boost_run, pulse_frequency_mode}), 16'h0003);
    boost_enable = 1'b0;
    @(negedge clk);
    chk(16'({boost_run, pulse_frequency_mode}), 16'h0000);
    stop_test;
  end
endmodule
bind rpb_top rpb_top_asserts #(.SOFT_START_CYCLES(SOFT_START_CYCLES)) rpb_top_asserts_inst (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .device_awake(device_awake),
  .color_set_enable(color_set_enable), .boost_enable(boost_enable),
  .light_load_sink_enable(light_load_sink_enable), .pwm_rate_select_hi(pwm_rate_select_hi),
  .pwm_rate_select_lo(pwm_rate_select_lo), .led_sink_on(led_sink_on),
  .led_current_scale(led_current_scale), .boost_run(boost_run),
  .pulse_frequency_mode(pulse_frequency_mode), .boost_switch_clk(boost_switch_clk),
  .boost_level(boost_level), .light_load_sink_on(light_load_sink_on));
`default_nettype wire
